// ### rtl/tif_flag.sv
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module tif_flag #(
  parameter int DATA_W = 8
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // Register port
  input  wire logic [3:0]        addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rd_data,
  // Serial bus pins
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  // Shift engine side
  input  wire logic              shifter_free,
  input  wire logic              rx_byte_valid,
  input  wire logic [7:0]        rx_byte,
  output logic                   shift_load,
  output logic      [7:0]        shift_tx_byte,
  // Status outputs
  output logic                   irq,
  output logic                   bus_busy
);

  typedef struct packed {
    logic [DATA_W-1:0] ctrl;
    logic              flag;
    logic              armed;
    logic              tbe;
    logic              rbf;
    logic              busy;
    logic              thr_valid;
    logic [7:0]        thr;
    logic [7:0]        rhr;
    logic              rx_pend;
    logic [7:0]        rx_pend_byte;
    logic [3:0]        edge_cnt;
    logic              shift_load;
    logic [7:0]        shift_byte;
    logic [DATA_W-1:0] rd_data;
  } tif_flag_s;

  tif_flag_s r;
  tif_flag_s next_r;

  logic scl_level;
  logic scl_rise;
  logic sda_fall;
  logic sda_rise;

  // Pin synchronisers
  // Only the second stage of each chain reads the first
  tif_sync u_scl_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin     (scl_in),
    .level   (scl_level),
    .rise    (scl_rise),
    .fall    ()
  );

  tif_sync u_sda_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin     (sda_in),
    .level   (),
    .rise    (sda_rise),
    .fall    (sda_fall)
  );

  // Decoded control bits
  logic enabled;
  logic i2c_fmt;
  logic tx_mode;
  logic tx_on;
  logic rx_on;

  assign enabled = r.ctrl[tif_pkg::CTRL_EN_BIT];
  assign i2c_fmt = r.ctrl[tif_pkg::CTRL_I2C_BIT];
  assign tx_mode = r.ctrl[tif_pkg::CTRL_TX_BIT];
  assign tx_on   = enabled & tx_mode;
  assign rx_on   = enabled & ~tx_mode;

  // Bus conditions: data edge while the clock is high
  logic start_det;
  logic stop_det;

  assign start_det = enabled & i2c_fmt & sda_fall & scl_level;
  assign stop_det  = enabled & i2c_fmt & sda_rise & scl_level;

  // Last serial clock rise of a byte in synchronous format
  logic last_edge;

  assign last_edge = (r.edge_cnt == tif_pkg::BYTE_EDGES - tif_pkg::CNT_STEP);

  // Register access decode
  logic wr_ctrl;
  logic wr_stat;
  logic wr_data_reg;
  logic rd_stat;
  logic rd_data_reg;

  assign wr_ctrl     = wr_en & (addr == tif_pkg::CTRL_OFS);
  assign wr_stat     = wr_en & (addr == tif_pkg::STAT_OFS);
  assign wr_data_reg = wr_en & (addr == tif_pkg::DATA_OFS);
  assign rd_stat     = rd_en & (addr == tif_pkg::STAT_OFS);
  assign rd_data_reg = rd_en & (addr == tif_pkg::DATA_OFS);

  // Clearing write: a 0 in the flag bit after an arming read
  logic clear_req;

  assign clear_req = wr_stat & r.armed & ~wr_data[tif_pkg::STAT_FLAG_BIT];

  // Status word as software sees it
  // Only the flag bit takes write data; a status write also clears the arm bit unless a same-cycle read of the flag as 1 arms it
  logic [DATA_W-1:0] stat_word;

  always_comb begin
    stat_word                          = '0;
    stat_word[tif_pkg::STAT_FLAG_BIT]  = r.flag;
    stat_word[tif_pkg::STAT_TBE_BIT]   = r.tbe;
    stat_word[tif_pkg::STAT_RBF_BIT]   = r.rbf;
    stat_word[tif_pkg::STAT_BUSY_BIT]  = r.busy;
    stat_word[tif_pkg::STAT_ARM_BIT]   = r.armed;
    stat_word[tif_pkg::STAT_PEND_BIT]  = r.rx_pend;
  end

  // Set events for the buffer flags and the transfer flag
  logic tbe_set;
  logic rbf_set;
  logic end_set;
  logic tx_move;
  logic any_set;

  // Next-state logic
  always_comb begin
    next_r            = r;
    next_r.rd_data    = '0;
    next_r.shift_load = 1'b0;
    tbe_set           = 1'b0;
    rbf_set           = 1'b0;
    end_set           = 1'b0;
    tx_move           = 1'b0;
    any_set           = 1'b0;

    // Control register write
    if (wr_ctrl) begin
      next_r.ctrl = wr_data;
    end

    // Bus busy tracking in bus format
    if (start_det) begin
      next_r.busy = 1'b1;
    end else if (stop_det || !enabled) begin
      next_r.busy = 1'b0;
    end

    // A start in receive mode only marks the bus busy
    // Start in transmit mode sets the buffer-empty flag; the holding register keeps its byte
    if (start_det && tx_mode) begin
      tbe_set = 1'b1;
    end

    // Holding register moves into the idle shift register
    // The pending load pulse holds back a byte written during the move for one cycle
    if (tx_on && shifter_free && r.thr_valid && !r.shift_load) begin
      tx_move           = 1'b1;
      next_r.shift_load = 1'b1;
      next_r.shift_byte = r.thr;
      next_r.thr_valid  = 1'b0;
      tbe_set           = 1'b1;
    end

    // Software data write fills the holding register
    if (wr_data_reg) begin
      next_r.thr       = wr_data[7:0];
      next_r.thr_valid = 1'b1;
    end

    // Buffer-empty: a data write in the same cycle refills it
    if (wr_data_reg) begin
      next_r.tbe = 1'b0;
    end else if (tbe_set) begin
      next_r.tbe = 1'b1;
    end else if (stop_det) begin
      next_r.tbe = 1'b0;
    end

    // Received byte: straight to holding, or parked until a read
    // A byte arriving while full is parked; a later one overwrites it
    if (rx_on && rx_byte_valid) begin
      if (!r.rbf || rd_data_reg) begin
        next_r.rhr = rx_byte;
        rbf_set    = 1'b1;
      end else begin
        next_r.rx_pend      = 1'b1;
        next_r.rx_pend_byte = rx_byte;
      end
    end else if (rd_data_reg && r.rx_pend) begin
      next_r.rhr     = r.rx_pend_byte;
      next_r.rx_pend = 1'b0;
      rbf_set        = 1'b1;
    end

    // Buffer-full: a refill wins over the clear by a data read
    if (rbf_set) begin
      next_r.rbf = 1'b1;
    end else if (rd_data_reg) begin
      next_r.rbf = 1'b0;
    end

    // Byte end counting on the serial clock in synchronous format
    // Counter restarts whenever the block is off or in bus format
    if (!enabled || i2c_fmt) begin
      next_r.edge_cnt = tif_pkg::CNT_RST;
    end else if (scl_rise) begin
      if (last_edge) begin
        next_r.edge_cnt = tif_pkg::CNT_RST;
        end_set         = 1'b1;
      end else begin
        next_r.edge_cnt = r.edge_cnt + tif_pkg::CNT_STEP;
      end
    end

    // Read of the flag as 1 arms the clear and wins over a status write, which otherwise disarms
    if (rd_stat && r.flag) begin
      next_r.armed = 1'b1;
    end else if (wr_stat) begin
      next_r.armed = 1'b0;
    end

    // Transfer flag: set wins, written 1 ignored, clear needs arming
    any_set = tbe_set | rbf_set | end_set;
    if (any_set) begin
      next_r.flag = 1'b1;
    end else if (clear_req) begin
      next_r.flag = 1'b0;
    end

    // Read data, valid in the cycle after the strobe
    if (rd_en) begin
      case (addr)
        tif_pkg::CTRL_OFS: begin
          next_r.rd_data = r.ctrl;
        end
        tif_pkg::STAT_OFS: begin
          next_r.rd_data = stat_word;
        end
        tif_pkg::DATA_OFS: begin
          next_r.rd_data = DATA_W'(r.rhr);
        end
        default: begin
          next_r.rd_data = '0;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r.ctrl         <= DATA_W'(tif_pkg::CTRL_RST);
      r.flag         <= 1'b0;
      r.armed        <= 1'b0;
      r.tbe          <= 1'b0;
      r.rbf          <= 1'b0;
      r.busy         <= 1'b0;
      r.thr_valid    <= 1'b0;
      r.thr          <= 8'h00;
      r.rhr          <= 8'h00;
      r.rx_pend      <= 1'b0;
      r.rx_pend_byte <= 8'h00;
      r.edge_cnt     <= tif_pkg::CNT_RST;
      r.shift_load   <= 1'b0;
      r.shift_byte   <= 8'h00;
      r.rd_data      <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from state
  assign rd_data       = r.rd_data;
  assign shift_load    = r.shift_load;
  assign shift_tx_byte = r.shift_byte;
  // Interrupt request is the flag itself, held until cleared
  assign irq           = r.flag;
  assign bus_busy      = r.busy;

endmodule

// ### rtl/tif_pkg.sv
package tif_pkg;

  // Register byte offsets
  localparam logic [3:0] CTRL_OFS       = 4'h0;
  localparam logic [3:0] STAT_OFS       = 4'h4;
  localparam logic [3:0] DATA_OFS       = 4'h8;

  // Control register fields
  localparam int         CTRL_EN_BIT    = 0;
  localparam int         CTRL_I2C_BIT   = 1;
  localparam int         CTRL_TX_BIT    = 2;
  localparam logic [7:0] CTRL_RST       = 8'h02;

  // Status register fields
  localparam int         STAT_FLAG_BIT  = 0;
  localparam int         STAT_TBE_BIT   = 1;
  localparam int         STAT_RBF_BIT   = 2;
  localparam int         STAT_BUSY_BIT  = 3;
  localparam int         STAT_ARM_BIT   = 4;
  localparam int         STAT_PEND_BIT  = 5;

  // Serial clock edges in one clocked-synchronous byte
  localparam logic [3:0] BYTE_EDGES     = 4'h8;
  localparam logic [3:0] CNT_STEP       = 4'h1;
  localparam logic [3:0] CNT_RST        = 4'h0;

endpackage

// ### rtl/tif_sync.sv
`timescale 1ns/1ps
module tif_sync (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Raw pin level
  input  wire logic pin,
  // Filtered level and its edges
  output logic      level,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic rise;
    logic fall;
  } tif_sync_s;

  tif_sync_s r;
  tif_sync_s next_r;

  // Three-stage chain; a change counts once stages two and three agree
  always_comb begin
    next_r      = r;
    next_r.s1   = pin;
    next_r.s2   = r.s1;
    next_r.s3   = r.s2;
    next_r.rise = 1'b0;
    next_r.fall = 1'b0;
    if (r.s2 == r.s3 && r.s3 != r.level) begin
      next_r.level = r.s3;
      next_r.rise  = r.s3;
      next_r.fall  = ~r.s3;
    end
  end

  // State register; pins idle high
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, level: 1'b1, rise: 1'b0, fall: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign level = r.level;
  assign rise  = r.rise;
  assign fall  = r.fall;

endmodule

// ### verif/tb_iic_transfer_interrupt_flag.sv
`timescale 1ns/1ps
module tb_iic_transfer_interrupt_flag;
  logic       ref_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wr_data = 8'h00;
  logic       wr_en = 1'b0;
  logic       rd_en = 1'b0;
  logic [7:0] rd_data;
  logic       scl;
  logic       sda;
  logic       shifter_free = 1'b0;
  logic       rx_byte_valid = 1'b0;
  logic [7:0] rx_byte = 8'h00;
  logic       shift_load;
  logic [7:0] shift_tx_byte;
  logic       irq;
  logic       bus_busy;
  int         num_errors = 0;
  int         n_tests = 0;
  int         cycles = 0;
  // Clock
  always #5 ref_clk = ~ref_clk;
  tif_bus_model bus (.ref_clk(ref_clk), .scl(scl), .sda(sda));
  tif_flag dut (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .scl_in(scl), .sda_in(sda),
    .shifter_free(shifter_free), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
    .shift_load(shift_load), .shift_tx_byte(shift_tx_byte), .irq(irq), .bus_busy(bus_busy));
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    #1;
  endtask
  task automatic rx(input logic [7:0] b);
    @(posedge ref_clk);
    rx_byte_valid <= 1'b1;
    rx_byte <= b;
    @(posedge ref_clk);
    rx_byte_valid <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    chk(rd_data & m, e);
  endtask
  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk(irq, 1'b0);
    rd(4'hc, 8'hff, 8'h00);
    wr(tif_pkg::CTRL_OFS, 8'h03);
    rx(8'h3c);
    chk(irq, 1'b1);
    wr(tif_pkg::STAT_OFS, 8'h00);
    chk(irq, 1'b1);
    rd(tif_pkg::STAT_OFS, 8'h05, 8'h05);
    wr(tif_pkg::STAT_OFS, 8'h01);
    chk(irq, 1'b1);
    rd(tif_pkg::STAT_OFS, 8'h01, 8'h01);
    wr(tif_pkg::STAT_OFS, 8'h00);
    chk(irq, 1'b0);
    wr(tif_pkg::STAT_OFS, 8'h01);
    chk(irq, 1'b0);
    rd(tif_pkg::DATA_OFS, 8'hff, 8'h3c);
    wr(tif_pkg::CTRL_OFS, 8'h07);
    bus.start();
    chk({irq, bus_busy}, 8'h03);
    rd(tif_pkg::STAT_OFS, 8'h0f, 8'h0b);
    wr(tif_pkg::STAT_OFS, 8'h00);
    bus.stop();
    chk({irq, bus_busy}, 8'h00);
    shifter_free <= 1'b1;
    wr(tif_pkg::DATA_OFS, 8'ha5);
    @(posedge ref_clk);
    #1 chk({shift_load, irq}, 8'h03);
    chk(shift_tx_byte, 8'ha5);
    rd(tif_pkg::STAT_OFS, 8'h03, 8'h03);
    wr(tif_pkg::STAT_OFS, 8'h00);
    wr(tif_pkg::CTRL_OFS, 8'h01);
    bus.clocks(7);
    chk(irq, 1'b0);
    bus.clocks(1);
    chk(irq, 1'b1);
    rd(tif_pkg::STAT_OFS, 8'h01, 8'h01);
    wr(tif_pkg::STAT_OFS, 8'h00);
    rx(8'h11);
    chk(irq, 1'b1);
    rd(tif_pkg::STAT_OFS, 8'h05, 8'h05);
    wr(tif_pkg::STAT_OFS, 8'h00);
    chk(irq, 1'b0);
    rx(8'h22);
    chk(irq, 1'b0);
    rd(tif_pkg::STAT_OFS, 8'h25, 8'h24);
    rd(tif_pkg::DATA_OFS, 8'hff, 8'h11);
    chk(irq, 1'b1);
    rd(tif_pkg::DATA_OFS, 8'hff, 8'h22);
    rd(tif_pkg::STAT_OFS, 8'h05, 8'h01);
    stop_test();
  end
endmodule

// ### verif/tif_bus_model.sv
`timescale 1ns/1ps
module tif_bus_model (
  // Clock
  input wire logic ref_clk,
  // Bus lines, pulled up when idle
  output logic     scl,
  output logic     sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic hold();
    repeat (8) @(posedge ref_clk);
  endtask
  // Data falls while clock high
  task automatic start();
    @(posedge ref_clk);
    sda <= 1'b0;
    hold();
    scl <= 1'b0;
    hold();
  endtask
  // Data rises while clock high
  task automatic stop();
    @(posedge ref_clk);
    sda <= 1'b0;
    hold();
    scl <= 1'b1;
    hold();
    sda <= 1'b1;
    hold();
  endtask
  // Serial clock rises, each ending high
  task automatic clocks(input int n);
    @(posedge ref_clk);
    repeat (n) begin
      scl <= 1'b0;
      hold();
      scl <= 1'b1;
      hold();
    end
  endtask
endmodule

// ### verif/tif_flag_checker.sv
`timescale 1ns/1ps
module tif_flag_checker #(
  parameter int DATA_W = 8
) (
  // Watched ports
  input wire logic              ref_clk,
  input wire logic              rst_n,
  input wire logic [3:0]        addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic              wr_en,
  input wire logic              rd_en,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic              shifter_free,
  input wire logic              rx_byte_valid,
  input wire logic              shift_load,
  input wire logic              irq
);
  logic armed;
  wire  st_wr = wr_en && addr == tif_pkg::STAT_OFS;
  wire  st_rd = rd_en && addr == tif_pkg::STAT_OFS;
  logic [DATA_W-1:0] ctrl_sh;
  logic              rbf_sh;
  logic              pend_sh;
  wire  dat_rd  = rd_en && addr == tif_pkg::DATA_OFS;
  wire  rx_on   = ctrl_sh[tif_pkg::CTRL_EN_BIT] && !ctrl_sh[tif_pkg::CTRL_TX_BIT];
  wire  rx_take = rx_byte_valid && rx_on && (!rbf_sh || dat_rd);
  // Shadow of the receive path: mode, buffer-full and a parked byte
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_sh <= DATA_W'(tif_pkg::CTRL_RST);
      rbf_sh  <= 1'b0;
      pend_sh <= 1'b0;
    end else begin
      if (wr_en && addr == tif_pkg::CTRL_OFS) ctrl_sh <= wr_data;
      if (rx_take || (dat_rd && pend_sh)) rbf_sh <= 1'b1;
      else if (dat_rd) rbf_sh <= 1'b0;
      if (rx_byte_valid && rx_on && !rx_take) pend_sh <= 1'b1;
      else if (dat_rd && !(rx_byte_valid && rx_on)) pend_sh <= 1'b0;
    end
  end
  // Tracks a status read that saw the flag set
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) armed <= 1'b0;
    else if (st_wr) armed <= 1'b0;
    else if (st_rd && irq) armed <= 1'b1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  rd_idle_a: assert property (!$past(rd_en) |-> rd_data == '0)
    else $error("read data not idle");
  rd_flag_a: assert property ($past(st_rd) |-> rd_data[tif_pkg::STAT_FLAG_BIT] == $past(irq))
    else $error("status read flag wrong");
  unmapped_a: assert property ($past(rd_en) && $past(addr) > 4'h8 |-> rd_data == '0)
    else $error("unmapped read not zero");
  flag_hold_a: assert property (irq && !(armed && st_wr && !wr_data[0]) |=> irq)
    else $error("flag dropped without clear");
  flag_clear_a: assert property (armed && st_wr && !wr_data[0] && !rx_byte_valid
    |=> !irq || shift_load)
    else $error("armed clear ignored");
  no_wr_set_a: assert property (st_wr && wr_data[0] && !irq && !rx_byte_valid
    |=> !irq || shift_load)
    else $error("write set the flag");
  rx_set_a: assert property (rx_take |=> irq)
    else $error("rx byte did not set flag");
  load_set_a: assert property (shift_load |-> irq && $past(shifter_free))
    else $error("shift load without flag");
endmodule

bind tif_flag tif_flag_checker #(.DATA_W(DATA_W)) chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .shifter_free(shifter_free), .rx_byte_valid(rx_byte_valid), .shift_load(shift_load), .irq(irq));
